// File: hdl/cre_regs.svh
`ifndef CRE_REGS_SVH
`define CRE_REGS_SVH

// register byte offsets
`define CRE_OFF_STATUS 12'h000
`define CRE_OFF_EPC 12'h004
`define CRE_OFF_ENTRY_HI 12'h008
`define CRE_OFF_ENTRY_LO 12'h00c
`define CRE_OFF_INDEX 12'h010
`define CRE_OFF_RANDOM 12'h014
`define CRE_OFF_WIRED 12'h018
`define CRE_OFF_CONFIG 12'h01c
`define CRE_OFF_TLB_CMD 12'h020
`define CRE_OFF_BOOT_INFO 12'h024
`define CRE_OFF_PRID 12'h028

// boot vectors and segment translation
`define CRE_BOOT_VEC32 32'hbfc0_0000
`define CRE_BOOT_VEC64 64'hffff_ffff_bfc0_0000
`define CRE_BOOT_PHYS 32'h1fc0_0000
`define CRE_SEG_MASK 32'h1fff_ffff

// status register fields
`define CRE_SR_IEC 0
`define CRE_SR_KUC 1
`define CRE_SR_ERL 2
`define CRE_SR_ISC 16
`define CRE_SR_SOFT 20
`define CRE_SR_TS 21
`define CRE_SR_BEV 22
`define CRE_SR_RESET 32'h0041_0000

// index register fields
`define CRE_INX_LSB 8
`define CRE_INX_MSB 13
`define CRE_INX_MISS 31

// entry high compare field: page number and process id
`define CRE_HI_CMP_MSB 31
`define CRE_HI_CMP_LSB 6

// replacement bounds
`define CRE_RANDOM_TOP 6'h3f
`define CRE_WIRED_RESET 6'h00

// tlb command bits
`define CRE_CMD_WRITE_IDX 0
`define CRE_CMD_PROBE 1

// config bits loaded from the mode stream
`define CRE_CFG_MODE_W 8

// processor id, arbitrary neutral value
`define CRE_PRID_VALUE 32'h0000_0a01

`endif

// File: hdl/cre_pkg.sv
`default_nettype none
package cre_pkg;
    typedef enum logic [1:0] {
        CRE_ST_ENTRY = 2'b01,
        CRE_ST_RUN = 2'b10
    } cre_state_t;
    typedef logic [31:0] cre_word_t;
    typedef logic [5:0] cre_idx_t;
    typedef logic [63:0] cre_match_t;
endpackage
`default_nettype wire

// File: hdl/cre_reset_entry.sv
// Overview of operation
// [RULE1] 32-bit variant boots at 0xbfc00000
// [RULE2] 64-bit variant boots at sign-extended vector
// [RULE3] vector maps to 0x1fc00000, uncached, unmapped
// [RULE4] reset captures executing pc as return pc
// [RULE5] other registers keep their contents through reset
// [RULE6] kernel mode, interrupts off, bootstrap vectors on
// [RULE7] 32-bit: shutdown flag clear with mmu, else set
// [RULE8] 64-bit: soft indicator clear hard, set soft/nmi
// [RULE9] 64-bit: any reset sets error level
// [RULE10] software clears cache isolate before data access
// [RULE11] hard reset: random to top, wired to zero
// [RULE12] config bits loaded from boot mode stream
// [RULE13] reset never invalidates the caches
// [RULE14] duplicate tlb match locks shutdown until reset
// [RULE15] cache fetches only from burst-capable memory
// [RULE16] hard reset cause not distinguished from power-up
// [RULE17] software sets status before uncached accesses
// [RULE18] indexed write copies entry registers into tlb
// [RULE19] probe reports match index or negative miss
// [RULE20] boot fetch ignores cache and tlb contents
`default_nettype none
`include "cre_regs.svh"
module cre_reset_entry (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire cre_pkg::cre_word_t pwdata,
    output logic pready,
    output logic pslverr,
    output cre_pkg::cre_word_t prdata,
    input wire logic soft_reset_req,
    input wire logic nmi_req,
    input wire cre_pkg::cre_word_t core_pc,
    input wire logic variant_64,
    input wire logic mmu_present,
    input wire logic rom_burst_ok,
    input wire logic [7:0] mode_stream,
    output logic fetch_start,
    output logic [63:0] fetch_vaddr,
    output cre_pkg::cre_word_t fetch_paddr,
    output logic fetch_uncached,
    output logic fetch_mapped,
    output logic fetch_cacheable,
    output logic tlb_shutdown_flag,
    output cre_pkg::cre_word_t status_register
);
    import cre_pkg::*;

    cre_state_t state_r;
    logic hard_r;
    logic var64_r;
    logic mmu_r;
    logic burst_r;
    cre_word_t status_r;
    cre_word_t exception_return_pc_r;
    cre_word_t entry_high_register_r;
    cre_word_t entry_low_register_r;
    cre_word_t entry_index_register_r;
    cre_idx_t random_r;
    cre_idx_t wired_r;
    logic [7:0] config_r;
    logic shutdown_r;
    logic fetch_start_r;
    logic [63:0] fetch_vaddr_r;
    cre_word_t fetch_paddr_r;
    logic fetch_uncached_r;
    logic fetch_mapped_r;
    logic fetch_cacheable_r;
    cre_word_t prdata_r;
    logic pslverr_r;
    cre_word_t tlb_hi [0:63];
    cre_word_t tlb_lo [0:63];
    cre_match_t match;

    logic entry;
    logic v64;
    logic soft_evt;
    logic setup;
    logic wr;
    logic cmd_write;
    logic cmd_probe;
    cre_idx_t sel_idx;
    cre_idx_t random_nxt;

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == `CRE_OFF_STATUS) || (a == `CRE_OFF_EPC)
            || (a == `CRE_OFF_ENTRY_HI) || (a == `CRE_OFF_ENTRY_LO)
            || (a == `CRE_OFF_INDEX) || (a == `CRE_OFF_RANDOM)
            || (a == `CRE_OFF_WIRED) || (a == `CRE_OFF_CONFIG)
            || (a == `CRE_OFF_TLB_CMD) || (a == `CRE_OFF_BOOT_INFO)
            || (a == `CRE_OFF_PRID);
    endfunction

    function automatic logic multi_hit(input cre_match_t m);
        multi_hit = (m & (m - 64'h1)) != 64'h0;
    endfunction

    function automatic cre_idx_t first_hit(input cre_match_t m);
        first_hit = 6'h00;
        for (int i = 63; i >= 0; i--) begin
            if (m[i]) begin
                first_hit = 6'(i);
            end
        end
    endfunction

    assign entry = (state_r == CRE_ST_ENTRY) && clk_en;
    // variant strap is live on a hard entry, held afterwards
    assign v64 = hard_r ? variant_64 : var64_r;
    assign soft_evt = (soft_reset_req || nmi_req) && (state_r == CRE_ST_RUN);
    assign setup = psel && !penable && clk_en;
    assign wr = psel && penable && pwrite && clk_en;
    assign cmd_write = wr && (paddr == `CRE_OFF_TLB_CMD) && pwdata[`CRE_CMD_WRITE_IDX];
    assign cmd_probe = wr && (paddr == `CRE_OFF_TLB_CMD) && pwdata[`CRE_CMD_PROBE];
    assign sel_idx = entry_index_register_r[`CRE_INX_MSB:`CRE_INX_LSB];
    assign random_nxt = (random_r == wired_r) ? `CRE_RANDOM_TOP : random_r - 6'h01;

    // zero wait states; a frozen clock enable stretches the access
    assign pready = clk_en;
    assign pslverr = pslverr_r;
    assign prdata = prdata_r;
    assign fetch_start = fetch_start_r;
    assign fetch_vaddr = fetch_vaddr_r;
    assign fetch_paddr = fetch_paddr_r;
    assign fetch_uncached = fetch_uncached_r;
    assign fetch_mapped = fetch_mapped_r;
    assign fetch_cacheable = fetch_cacheable_r;
    assign tlb_shutdown_flag = shutdown_r;
    assign status_register = {status_r[31:`CRE_SR_TS + 1], shutdown_r,
        status_r[`CRE_SR_TS - 1:0]};

    // entry sequencer: hard reset release or soft/nmi event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= CRE_ST_ENTRY;
            hard_r <= 1'b1;
        end else if (clk_en) begin
            if (entry) begin
                state_r <= CRE_ST_RUN;
                hard_r <= 1'b0;
            end else if (soft_evt) begin
                state_r <= CRE_ST_ENTRY;
            end
        end
    end

    // straps sampled after release, never inside the async reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            var64_r <= 1'b0;
            mmu_r <= 1'b0;
            burst_r <= 1'b0;
            config_r <= 8'h00;
        end else if (entry && hard_r) begin
            var64_r <= variant_64;
            mmu_r <= mmu_present;
            burst_r <= rom_burst_ok;
            // [RULE12] mode stream load
            config_r <= mode_stream;
        end
    end

    // [RULE16] one hard path, no power-up distinction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_start_r <= 1'b0;
            fetch_vaddr_r <= 64'h0;
            fetch_paddr_r <= 32'h0;
            fetch_uncached_r <= 1'b1;
            fetch_mapped_r <= 1'b0;
            fetch_cacheable_r <= 1'b0;
        end else if (clk_en) begin
            fetch_start_r <= entry;
            if (entry) begin
                // [RULE1] [RULE2] boot vector select
                fetch_vaddr_r <= v64 ? `CRE_BOOT_VEC64 : {32'h0, `CRE_BOOT_VEC32};
                // [RULE3] segment strip to physical
                fetch_paddr_r <= `CRE_BOOT_VEC32 & `CRE_SEG_MASK;
                // [RULE20] [RULE13] bypass cache and tlb
                fetch_uncached_r <= 1'b1;
                fetch_mapped_r <= 1'b0;
                // [RULE15] boot segment never cached
                fetch_cacheable_r <= 1'b0;
            end
        end
    end

    // [RULE4] [RULE5] return pc capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exception_return_pc_r <= 32'h0;
        end else if (entry) begin
            exception_return_pc_r <= core_pc;
        end
    end

    // entry forcing wins over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= `CRE_SR_RESET;
        end else if (entry) begin
            // [RULE6] kernel, interrupts off
            status_r[`CRE_SR_KUC] <= 1'b0;
            status_r[`CRE_SR_IEC] <= 1'b0;
            status_r[`CRE_SR_BEV] <= 1'b1;
            if (v64) begin
                // [RULE9] error level set
                status_r[`CRE_SR_ERL] <= 1'b1;
                // [RULE8] soft indicator by cause
                status_r[`CRE_SR_SOFT] <= !hard_r;
            end
        end else if (wr && (paddr == `CRE_OFF_STATUS)) begin
            // [RULE10] [RULE17] software clears isolate
            status_r <= pwdata;
        end
    end

    // [RULE14] shutdown sticky until hard reset; any 64-bit entry also clears it, a 32-bit soft entry keeps it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shutdown_r <= 1'b0;
        end else if (entry) begin
            // [RULE7] shutdown flag reset value
            shutdown_r <= (v64 || !hard_r) ? shutdown_r && !v64 :
                !mmu_present;
        end else if (cmd_probe && multi_hit(match)) begin
            shutdown_r <= 1'b1;
        end
    end

    // tlb storage keeps no reset: contents are arbitrary at boot
    // [RULE18] indexed write
    always_ff @(posedge pclk) begin
        if (cmd_write && !shutdown_r) begin
            tlb_hi[sel_idx] <= entry_high_register_r;
            tlb_lo[sel_idx] <= entry_low_register_r;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 64; g++) begin : g_cmp
            assign match[g] = tlb_hi[g][`CRE_HI_CMP_MSB:`CRE_HI_CMP_LSB]
                == entry_high_register_r[`CRE_HI_CMP_MSB:`CRE_HI_CMP_LSB];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entry_high_register_r <= 32'h0;
            entry_low_register_r <= 32'h0;
        end else if (wr) begin
            if (paddr == `CRE_OFF_ENTRY_HI) begin
                entry_high_register_r <= pwdata;
            end else if (paddr == `CRE_OFF_ENTRY_LO) begin
                entry_low_register_r <= pwdata;
            end
        end
    end

    // probe result wins over a plain index write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            entry_index_register_r <= 32'h0;
        end else if (cmd_probe) begin
            // [RULE19] probe hit or miss
            entry_index_register_r <= 32'h0;
            if (match == 64'h0) begin
                entry_index_register_r[`CRE_INX_MISS] <= 1'b1;
            end else begin
                entry_index_register_r[`CRE_INX_MSB:`CRE_INX_LSB] <= first_hit(match);
            end
        end else if (wr && (paddr == `CRE_OFF_INDEX)) begin
            entry_index_register_r <= 32'h0;
            entry_index_register_r[`CRE_INX_MSB:`CRE_INX_LSB] <=
                pwdata[`CRE_INX_MSB:`CRE_INX_LSB];
        end
    end

    // [RULE11] replacement bounds on hard reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            random_r <= `CRE_RANDOM_TOP;
        end else if (entry && hard_r) begin
            random_r <= `CRE_RANDOM_TOP;
        end else if (clk_en) begin
            random_r <= random_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wired_r <= `CRE_WIRED_RESET;
        end else if (entry && hard_r) begin
            wired_r <= `CRE_WIRED_RESET;
        end else if (wr && (paddr == `CRE_OFF_WIRED)) begin
            wired_r <= pwdata[5:0];
        end
    end

    // read data latched in setup so it stands through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            pslverr_r <= !is_mapped(paddr);
            if (pwrite) begin
                prdata_r <= 32'h0;
            end else if (paddr == `CRE_OFF_STATUS) begin
                prdata_r <= status_register;
            end else if (paddr == `CRE_OFF_EPC) begin
                prdata_r <= exception_return_pc_r;
            end else if (paddr == `CRE_OFF_ENTRY_HI) begin
                prdata_r <= entry_high_register_r;
            end else if (paddr == `CRE_OFF_ENTRY_LO) begin
                prdata_r <= entry_low_register_r;
            end else if (paddr == `CRE_OFF_INDEX) begin
                prdata_r <= entry_index_register_r;
            end else if (paddr == `CRE_OFF_RANDOM) begin
                prdata_r <= {26'h0, random_r};
            end else if (paddr == `CRE_OFF_WIRED) begin
                prdata_r <= {26'h0, wired_r};
            end else if (paddr == `CRE_OFF_CONFIG) begin
                prdata_r <= {24'h0, config_r};
            end else if (paddr == `CRE_OFF_BOOT_INFO) begin
                prdata_r <= {28'h0, burst_r, mmu_r, var64_r, shutdown_r};
            end else if (paddr == `CRE_OFF_PRID) begin
                prdata_r <= `CRE_PRID_VALUE;
            end else begin
                prdata_r <= 32'h0;
            end
        end
    end

endmodule // cre_reset_entry
`default_nettype wire

// File: tb/cre_reset_entry_props.sv
`default_nettype none
`include "cre_regs.svh"
module cre_reset_entry_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic variant_64,
    input wire logic mmu_present,
    input wire logic fetch_start,
    input wire logic [63:0] fetch_vaddr,
    input wire cre_pkg::cre_word_t fetch_paddr,
    input wire logic fetch_uncached,
    input wire logic fetch_mapped,
    input wire logic fetch_cacheable,
    input wire logic tlb_shutdown_flag,
    input wire cre_pkg::cre_word_t status_register
);
    timeunit 1ns;
    timeprecision 1ns;
    import cre_pkg::*;
    logic seen_r;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // first pulse after reset is the hard entry, later ones are soft
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_r <= 1'b0;
        end else if (fetch_start) begin
            seen_r <= 1'b1;
        end
    end
    sequence s_fetch;
        fetch_start && clk_en;
    endsequence
    sequence s_hard32;
        fetch_start && !seen_r && !variant_64;
    endsequence
    sequence s_hard64;
        fetch_start && !seen_r && variant_64;
    endsequence
    sequence s_soft64;
        fetch_start && seen_r && variant_64;
    endsequence
    a_fetch_once: assert property (s_fetch |=> !fetch_start)
        else $error("fetch pulse too long");
    a_vec_32: assert property (fetch_start && !variant_64 |-> fetch_vaddr == {32'h0, `CRE_BOOT_VEC32})
        else $error("bad 32-bit vector");
    a_vec_64: assert property (fetch_start && variant_64 |-> fetch_vaddr == `CRE_BOOT_VEC64)
        else $error("bad 64-bit vector");
    a_boot_phys: assert property (fetch_start |-> fetch_paddr == `CRE_BOOT_PHYS)
        else $error("bad boot physical address");
    a_boot_route: assert property (fetch_start |-> fetch_uncached && !fetch_mapped && !fetch_cacheable)
        else $error("boot fetch not uncached and unmapped");
    a_kernel_mode: assert property (fetch_start |-> status_register[22] && status_register[1:0] == 2'b00)
        else $error("status not in kernel boot state");
    a_erl_set: assert property (fetch_start && variant_64 |-> status_register[`CRE_SR_ERL])
        else $error("error level clear after entry");
    a_ts_strap: assert property (s_hard32 |-> tlb_shutdown_flag == !mmu_present)
        else $error("shutdown flag wrong after hard entry");
    a_soft_clear: assert property (s_hard64 |-> !status_register[`CRE_SR_SOFT])
        else $error("soft bit set after hard entry");
    a_soft_set: assert property (s_soft64 |-> status_register[`CRE_SR_SOFT])
        else $error("soft bit clear after soft entry");
endmodule // cre_reset_entry_props
bind cre_reset_entry cre_reset_entry_props i_cre_reset_entry_props (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .variant_64(variant_64),
    .mmu_present(mmu_present),
    .fetch_start(fetch_start),
    .fetch_vaddr(fetch_vaddr),
    .fetch_paddr(fetch_paddr),
    .fetch_uncached(fetch_uncached),
    .fetch_mapped(fetch_mapped),
    .fetch_cacheable(fetch_cacheable),
    .tlb_shutdown_flag(tlb_shutdown_flag),
    .status_register(status_register)
);
`default_nettype wire

// File: tb/cre_boot_rom.sv
`default_nettype none
`include "cre_regs.svh"
module cre_boot_rom #(
    parameter logic BURST = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fetch_start,
    input wire cre_pkg::cre_word_t fetch_paddr,
    input wire logic fetch_cacheable,
    output logic burst_ok,
    output logic [7:0] fetch_count
);
    timeunit 1ns;
    timeprecision 1ns;
    import cre_pkg::*;
    assign burst_ok = BURST;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_count <= 8'h00;
        end else if (fetch_start && fetch_paddr == `CRE_BOOT_PHYS && !fetch_cacheable) begin
            fetch_count <= fetch_count + 8'h01;
        end
    end
endmodule // cre_boot_rom
`default_nettype wire

// File: tb/cre_reset_entry_tb.sv
`default_nettype none
`include "cre_regs.svh"
module cre_reset_entry_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cre_pkg::*;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
    logic soft_reset_req, nmi_req, variant_64, mmu_present, burst_ok;
    logic fetch_start, fetch_uncached, fetch_mapped, fetch_cacheable, tlb_shutdown_flag;
    logic [11:0] paddr;
    logic [63:0] fetch_vaddr;
    logic [7:0] mode_stream, fetch_count;
    cre_word_t pwdata, prdata, core_pc, fetch_paddr, status_register, rd, pc, lo, hi, r;
    cre_idx_t ix;
    logic [31:0] seed;
    int err_count, cmp_count;
    cre_reset_entry i_cre_reset_entry (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .soft_reset_req(soft_reset_req),
        .nmi_req(nmi_req), .core_pc(core_pc), .variant_64(variant_64),
        .mmu_present(mmu_present), .rom_burst_ok(burst_ok), .mode_stream(mode_stream),
        .fetch_start(fetch_start), .fetch_vaddr(fetch_vaddr), .fetch_paddr(fetch_paddr),
        .fetch_uncached(fetch_uncached), .fetch_mapped(fetch_mapped),
        .fetch_cacheable(fetch_cacheable), .tlb_shutdown_flag(tlb_shutdown_flag),
        .status_register(status_register));
    cre_boot_rom #(.BURST(1'b0)) i_cre_boot_rom (.pclk(pclk), .presetn(presetn),
        .fetch_start(fetch_start), .fetch_paddr(fetch_paddr),
        .fetch_cacheable(fetch_cacheable), .burst_ok(burst_ok), .fetch_count(fetch_count));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [63:0] exp_vaddr(input logic v64);
        return v64 ? `CRE_BOOT_VEC64 : {32'h0000_0000, `CRE_BOOT_VEC32};
    endfunction
    function automatic logic exp_ts(input logic v64, input logic mmu);
        return !v64 && !mmu;
    endfunction
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input cre_word_t d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no fixed wait count: only the watchdog ends a stalled access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string name, input logic [11:0] a, input cre_word_t exp,
        input cre_word_t mask);
        apb(1'b0, a, 32'h0);
        check(name, rd & mask, exp);
    endtask
    task automatic wait_fetch();
        int n;
        n = 0;
        while (fetch_start !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        check("fetch seen", n < 20, 1);
        check("kernel bits", {status_register[22], status_register[1:0]}, 3'b100);
        if (variant_64) check("error level", status_register[`CRE_SR_ERL], 1);
    endtask
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        close_out();
    end
    initial begin
        {presetn, psel, penable, pwrite, soft_reset_req, nmi_req, variant_64, mmu_present} = 0;
        clk_en = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0;
        core_pc = 32'h0;
        mode_stream = 8'h00;
        seed = 32'hd79a54b9;
        err_count = 0;
        cmp_count = 0;
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            presetn <= 1'b0;
            variant_64 <= i[0];
            mmu_present <= i[1];
            pc = rnd();
            r = rnd();
            core_pc <= pc;
            mode_stream <= r[7:0];
            repeat (i == 0 ? 20 : 2) @(posedge pclk);
            check("reset status", status_register, `CRE_SR_RESET);
            presetn <= 1'b1;
            wait_fetch();
            check("vaddr", fetch_vaddr, exp_vaddr(i[0]));
            check("paddr", fetch_paddr, `CRE_BOOT_PHYS);
            check("route", {fetch_uncached, fetch_mapped, fetch_cacheable}, 3'b100);
            check("shutdown", tlb_shutdown_flag, exp_ts(i[0], i[1]));
            if (i[0]) check("soft bit hard", status_register[`CRE_SR_SOFT], 0);
            rdchk("epc", `CRE_OFF_EPC, pc, 32'hffff_ffff);
            apb(1'b0, `CRE_OFF_RANDOM, 32'h0);
            check("random near top", rd[5:0] > 6'd50, 1);
            rdchk("wired", `CRE_OFF_WIRED, 32'h0, 32'h3f);
            rdchk("config", `CRE_OFF_CONFIG, {24'h0, r[7:0]}, 32'hff);
            r = {28'h0, 1'b0, i[1], i[0], exp_ts(i[0], i[1])};
            rdchk("boot info", `CRE_OFF_BOOT_INFO, r, 32'h0000_000f);
            rdchk("prid", `CRE_OFF_PRID, `CRE_PRID_VALUE, 32'hffff_ffff);
            apb(1'b0, 12'h030, 32'h0);
            check("unmapped", {err, rd}, {1'b1, 32'h0});
            check("rom count", fetch_count, 1);
            lo = rnd();
            apb(1'b1, `CRE_OFF_WIRED, 32'h5);
            apb(1'b1, `CRE_OFF_ENTRY_LO, lo);
            apb(1'b1, `CRE_OFF_STATUS, 32'h0);
            pc = rnd();
            core_pc <= pc;
            if (i[1]) nmi_req <= 1'b1;
            else soft_reset_req <= 1'b1;
            @(posedge pclk);
            nmi_req <= 1'b0;
            soft_reset_req <= 1'b0;
            wait_fetch();
            check("isolate clear", status_register[`CRE_SR_ISC], 0);
            check("shutdown soft", tlb_shutdown_flag, exp_ts(i[0], i[1]));
            if (i[0]) check("soft bit soft", status_register[`CRE_SR_SOFT], 1);
            rdchk("epc soft", `CRE_OFF_EPC, pc, 32'hffff_ffff);
            rdchk("wired kept", `CRE_OFF_WIRED, 32'h5, 32'h3f);
            rdchk("entry low kept", `CRE_OFF_ENTRY_LO, lo, 32'hffff_ffff);
            check("rom count soft", fetch_count, 2);
            if (!exp_ts(i[0], i[1])) begin
                // distinct pages first, so random contents cannot alias the probe
                for (int e = 0; e < 64; e++) begin
                    apb(1'b1, `CRE_OFF_ENTRY_HI, e << 12);
                    apb(1'b1, `CRE_OFF_INDEX, e << 8);
                    apb(1'b1, `CRE_OFF_TLB_CMD, 32'h1);
                end
                r = rnd();
                hi = (r | 32'h8000_0000) & 32'hffff_ffc0;
                ix = r[13:8];
                apb(1'b1, `CRE_OFF_ENTRY_HI, hi);
                apb(1'b1, `CRE_OFF_INDEX, {18'h0, ix, 8'h00});
                apb(1'b1, `CRE_OFF_TLB_CMD, 32'h1);
                apb(1'b1, `CRE_OFF_TLB_CMD, 32'h2);
                rdchk("probe hit", `CRE_OFF_INDEX, {18'h0, ix, 8'h0}, 32'h8000_3f00);
                apb(1'b1, `CRE_OFF_ENTRY_HI, 32'h4000_0000);
                apb(1'b1, `CRE_OFF_TLB_CMD, 32'h2);
                rdchk("probe miss", `CRE_OFF_INDEX, 32'h8000_0000, 32'h8000_0000);
                apb(1'b1, `CRE_OFF_ENTRY_HI, hi);
                apb(1'b1, `CRE_OFF_INDEX, {18'h0, ix ^ 6'h01, 8'h00});
                apb(1'b1, `CRE_OFF_TLB_CMD, 32'h1);
                apb(1'b1, `CRE_OFF_TLB_CMD, 32'h2);
                repeat (2) @(posedge pclk);
                check("dup shutdown", tlb_shutdown_flag, 1);
            end
        end
        @(posedge pclk);
        clk_en <= 1'b0;
        repeat (2) @(posedge pclk);
        check("frozen ready", pready, 0);
        clk_en <= 1'b1;
        close_out();
    end
endmodule // cre_reset_entry_tb
`default_nettype wire
